// ---- verilog/sas_pkg.sv ----
// Package for the auxiliary-settings and status block: register map, fields, reset values.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package sas_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sas_wb_req_t;

    // Register byte offsets.
    localparam logic [7:0] ADR_CTRL      = 8'h00;
    localparam logic [7:0] ADR_FMT_HI    = 8'h04;
    localparam logic [7:0] ADR_FMT_LO    = 8'h08;
    localparam logic [7:0] ADR_ILK_WORD_REPLY  = 8'h0C;
    localparam logic [7:0] ADR_VSRC_WORD_REPLY = 8'h10;
    localparam logic [7:0] ADR_CSRC_WORD_REPLY = 8'h14;
    localparam logic [7:0] ADR_RNG_WORD_REPLY  = 8'h18;
    localparam logic [7:0] ADR_QCOND     = 8'h1C;
    localparam logic [7:0] ADR_QENA      = 8'h20;
    localparam logic [7:0] ADR_QEVENT    = 8'h24;
    localparam logic [7:0] ADR_OCOND     = 8'h28;
    localparam logic [7:0] ADR_OENA      = 8'h2C;
    localparam logic [7:0] ADR_OEVENT    = 8'h30;
    localparam logic [7:0] ADR_SUM_CHAR  = 8'h34;

    // Control register field positions, and the word_reply last-character flag bit.
    localparam int CTRL_FMT   = 0;
    localparam int CTRL_SCPI  = 1;
    localparam int CTRL_ILK   = 2;
    localparam int CTRL_VSRC  = 3;
    localparam int CTRL_CSRC  = 5;
    localparam int CTRL_RNG10 = 7;
    localparam int CTRL_PIN1  = 8;
    localparam int CTRL_PIN2  = 9;
    localparam int SUM_LAST   = 8;

    // Reset values.
    localparam logic       RST_FMT   = 1'b0;
    localparam logic       RST_ILK   = 1'b0;
    localparam logic [1:0] RST_SRC   = 2'h0;
    localparam logic       RST_RNG10 = 1'b0;
    localparam logic       RST_PIN   = 1'b1;
    localparam logic [15:0] RST_ENA  = 16'h0000;

    // Programming source codes.
    localparam logic [1:0] SRC_FRONT = 2'h0;
    localparam logic [1:0] SRC_VOLT  = 2'h1;
    localparam logic [1:0] SRC_OHM   = 2'h2;

    // Serial link settings and the bit period they imply at 200 MHz.
    localparam int CLK_HZ        = 200000000;
    localparam int LINK_BAUD     = 115200;
    localparam int LINK_DATA     = 8;
    localparam int LINK_STOP     = 1;
    localparam logic [15:0] LINK_BIT_CYC = 16'(CLK_HZ / LINK_BAUD);

    // Status word_reply: six fields, each two letters and four hex digits, comma separated.
    localparam logic [2:0] SUM_FIELDS = 3'd6;
    localparam logic [2:0] SUM_COMMA  = 3'd6;
    localparam logic [2:0] SUM_LASTP  = 3'd5;

endpackage : sas_pkg

// ---- verilog/sas_aux_status.sv ----
// Auxiliary settings and status groups of the supply command interpreter, as Wishbone registers.
// Assumes synchronous inputs on clk_i; the serial parser writes settings and reads replies here.
`timescale 1ns/1ps
module sas_aux_status (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire sas_pkg::sas_wb_req_t wb_req_i,
    output logic                    wb_ack_o,
    output logic [31:0]             wb_dat_o,
    input  wire logic [15:0]        meas_volt_i,
    input  wire logic [15:0]        set_volt_i,
    input  wire logic [15:0]        meas_curr_i,
    input  wire logic [15:0]        set_curr_i,
    input  wire logic [15:0]        fault_cond_i,
    input  wire logic [15:0]        oper_cond_i,
    input  wire logic               interlock_input_i,
    output logic                    interlock_trip_o,
    output logic                    word_reply_o,
    output logic                    protocol_scpi_o,
    output logic [1:0]              volt_src_o,
    output logic [1:0]              curr_src_o,
    output logic                    range_10v_o,
    output logic                    pin_one_on_o,
    output logic                    pin_two_on_o,
    output logic [15:0]             link_bit_cycles_o
);
    import sas_pkg::*;

    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] rdata;
    logic        fmt_q;
    logic        scpi_q;
    logic        ilk_en_q;
    logic [1:0]  vsrc_q;
    logic [1:0]  csrc_q;
    logic        rng10_q;
    logic        pin1_q;
    logic        pin2_q;
    logic [15:0] cond_q   [2];
    logic [15:0] ena_q    [2];
    logic [15:0] event_q  [2];
    logic [15:0] cond_now [2];
    logic        ev_clr   [2];
    logic        ena_wr   [2];
    logic [2:0]  sum_f_q;
    logic [2:0]  sum_p_q;
    logic [7:0]  sum_char;
    logic        sum_last;
    logic        req;
    logic        wr_done;
    logic        rd_done;

    function automatic logic [31:0] bool_word_reply(input logic word, input logic b);
        if (!word)
        begin
            bool_word_reply = {24'h000000, 7'h18, b};
        end
        else if (b)
        begin
            bool_word_reply = 32'h00004F4E;
        end
        else
        begin
            bool_word_reply = 32'h004F4646;
        end
    endfunction : bool_word_reply

    function automatic logic [31:0] src_word_reply(input logic [1:0] src);
        case (src)
            SRC_VOLT: src_word_reply = 32'h00564F4C;
            SRC_OHM:  src_word_reply = 32'h00524553;
            default:  src_word_reply = 32'h00444947;
        endcase
    endfunction : src_word_reply

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        if (nib < 4'hA)
        begin
            hex_char = 8'h30 + {4'h0, nib};
        end
        else
        begin
            hex_char = 8'h37 + {4'h0, nib};
        end
    endfunction : hex_char

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // A request is answered one cycle after it appears; writes and the word_reply advance act at
    // the ack edge.
    assign req     = wb_req_i.cyc && wb_req_i.stb;
    assign wr_done = req && ack_q && wb_req_i.we;
    assign rd_done = req && ack_q && !wb_req_i.we;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            dat_q <= (req && !ack_q && !wb_req_i.we) ? rdata : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Settings register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fmt_q    <= RST_FMT;
            scpi_q   <= 1'b0;
            ilk_en_q <= RST_ILK;
            vsrc_q   <= RST_SRC;
            csrc_q   <= RST_SRC;
            rng10_q  <= RST_RNG10;
            pin1_q   <= RST_PIN;
            pin2_q   <= RST_PIN;
        end
        else if (wr_done && wb_req_i.adr == ADR_CTRL)
        begin
            if (wb_req_i.sel[0])
            begin
                fmt_q    <= wb_req_i.dat[CTRL_FMT];
                scpi_q   <= scpi_q || wb_req_i.dat[CTRL_SCPI];
                ilk_en_q <= wb_req_i.dat[CTRL_ILK];
                rng10_q  <= wb_req_i.dat[CTRL_RNG10];
                // A source code outside 0..2 is refused and the old source stays.
                if (wb_req_i.dat[CTRL_VSRC+1 -: 2] <= SRC_OHM)
                begin
                    vsrc_q <= wb_req_i.dat[CTRL_VSRC+1 -: 2];
                end
                if (wb_req_i.dat[CTRL_CSRC+1 -: 2] <= SRC_OHM)
                begin
                    csrc_q <= wb_req_i.dat[CTRL_CSRC+1 -: 2];
                end
            end
            if (wb_req_i.sel[1])
            begin
                pin1_q <= wb_req_i.dat[CTRL_PIN1];
                pin2_q <= wb_req_i.dat[CTRL_PIN2];
            end
        end
    end

    assign word_reply_o      = fmt_q;
    assign protocol_scpi_o   = scpi_q;
    assign interlock_trip_o  = ilk_en_q && interlock_input_i;
    assign volt_src_o        = vsrc_q;
    assign curr_src_o        = csrc_q;
    assign range_10v_o       = rng10_q;
    assign pin_one_on_o      = !pin1_q;
    assign pin_two_on_o      = !pin2_q;
    assign link_bit_cycles_o = LINK_BIT_CYC;

    // Status groups: index 0 is questionable (fault), index 1 is operation.
    assign cond_now[0] = fault_cond_i;
    assign cond_now[1] = oper_cond_i;
    // Events clear at the edge that captures the read data, so a rise landing in the
    // acknowledge cycle stays for the next read instead of vanishing unreported.
    assign ev_clr[0]   = req && !ack_q && !wb_req_i.we && wb_req_i.adr == ADR_QEVENT;
    assign ev_clr[1]   = req && !ack_q && !wb_req_i.we && wb_req_i.adr == ADR_OEVENT;
    assign ena_wr[0]   = wr_done && wb_req_i.adr == ADR_QENA;
    assign ena_wr[1]   = wr_done && wb_req_i.adr == ADR_OENA;

    for (genvar g = 0; g < 2; g++)
    begin : g_group
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                cond_q[g]  <= 16'h0000;
                ena_q[g]   <= RST_ENA;
                event_q[g] <= 16'h0000;
            end
            else
            begin
                cond_q[g] <= cond_now[g];
                if (ena_wr[g])
                begin
                    ena_q[g] <= merge16(ena_q[g], wb_req_i.dat, wb_req_i.sel);
                end
                // A new rising edge in the clearing cycle survives the clear.
                event_q[g] <= (ev_clr[g] ? 16'h0000 : event_q[g])
                            | (cond_now[g] & ~cond_q[g] & ena_q[g]);
            end
        end
    end

    // Status word_reply sequencer: each read of the word_reply register yields the next character.
    assign sum_last = (sum_f_q == SUM_FIELDS - 3'd1) && (sum_p_q == SUM_LASTP);

    always_comb
    begin
        logic [15:0] val;
        logic [15:0] tag;
        val = 16'h0000;
        tag = 16'h0000;
        case (sum_f_q)
            3'd0:    begin val = meas_volt_i;    tag = 16'h4D56; end
            3'd1:    begin val = set_volt_i;     tag = 16'h5056; end
            3'd2:    begin val = meas_curr_i;    tag = 16'h4D43; end
            3'd3:    begin val = set_curr_i;     tag = 16'h5043; end
            3'd4:    begin val = cond_now[1];    tag = 16'h5352; end
            default: begin val = cond_now[0];    tag = 16'h4652; end
        endcase
        case (sum_p_q)
            3'd0:    sum_char = tag[15:8];
            3'd1:    sum_char = tag[7:0];
            3'd2:    sum_char = hex_char(val[15:12]);
            3'd3:    sum_char = hex_char(val[11:8]);
            3'd4:    sum_char = hex_char(val[7:4]);
            3'd5:    sum_char = hex_char(val[3:0]);
            default: sum_char = 8'h2C;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sum_f_q <= 3'd0;
            sum_p_q <= 3'd0;
        end
        else if (wb_req_i.adr == ADR_SUM_CHAR && wr_done)
        begin
            sum_f_q <= 3'd0;
            sum_p_q <= 3'd0;
        end
        else if (wb_req_i.adr == ADR_SUM_CHAR && rd_done)
        begin
            if (sum_last)
            begin
                sum_f_q <= 3'd0;
                sum_p_q <= 3'd0;
            end
            else if (sum_p_q == SUM_COMMA)
            begin
                sum_f_q <= sum_f_q + 3'd1;
                sum_p_q <= 3'd0;
            end
            else
            begin
                sum_p_q <= sum_p_q + 3'd1;
            end
        end
    end

    // Read multiplexer.
    always_comb
    begin
        rdata = 32'h00000000;
        if (wb_req_i.adr == ADR_CTRL)
        begin
            rdata = {22'h000000, pin2_q, pin1_q, rng10_q, csrc_q, vsrc_q, ilk_en_q,
                     scpi_q, fmt_q};
        end
        else if (wb_req_i.adr == ADR_FMT_HI)
        begin
            rdata = fmt_q ? 32'h54455854 : 32'h44494749;
        end
        else if (wb_req_i.adr == ADR_FMT_LO)
        begin
            rdata = fmt_q ? 32'h00000000 : 32'h00000054;
        end
        else if (wb_req_i.adr == ADR_ILK_WORD_REPLY)
        begin
            rdata = bool_word_reply(fmt_q, interlock_trip_o);
        end
        else if (wb_req_i.adr == ADR_VSRC_WORD_REPLY)
        begin
            rdata = src_word_reply(vsrc_q);
        end
        else if (wb_req_i.adr == ADR_CSRC_WORD_REPLY)
        begin
            rdata = src_word_reply(csrc_q);
        end
        else if (wb_req_i.adr == ADR_RNG_WORD_REPLY)
        begin
            rdata = rng10_q ? 32'h00003130 : 32'h00000035;
        end
        else if (wb_req_i.adr == ADR_QCOND)
        begin
            rdata = {16'h0000, cond_now[0]};
        end
        else if (wb_req_i.adr == ADR_QENA)
        begin
            rdata = {16'h0000, ena_q[0]};
        end
        else if (wb_req_i.adr == ADR_QEVENT)
        begin
            rdata = {16'h0000, event_q[0]};
        end
        else if (wb_req_i.adr == ADR_OCOND)
        begin
            rdata = {16'h0000, cond_now[1]};
        end
        else if (wb_req_i.adr == ADR_OENA)
        begin
            rdata = {16'h0000, ena_q[1]};
        end
        else if (wb_req_i.adr == ADR_OEVENT)
        begin
            rdata = {16'h0000, event_q[1]};
        end
        else if (wb_req_i.adr == ADR_SUM_CHAR)
        begin
            rdata = {23'h000000, sum_last, sum_char};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_qev_read;
        req && !wb_req_i.we && wb_req_i.adr == ADR_QEVENT && !ack_q;
    endsequence

    sequence s_rise_masked(int g);
        !cond_q[0][0] && fault_cond_i[0] && ena_q[0][0];
    endsequence

    a_event_rise_set: assert property (s_rise_masked(0) |=> event_q[0][0])
        else $error("Enabled rising fault bit did not set its event bit.");

    a_mask_blocks_event: assert property (
        !ena_q[1][3] && !event_q[1][3] && !ev_clr[1] |=> !event_q[1][3])
        else $error("Masked operation bit reached its event bit.");

    a_event_read_clear: assert property (
        (s_qev_read and (cond_q[0] == fault_cond_i)) |=> event_q[0] == 16'h0000)
        else $error("Fault event register not cleared by its read.");

    a_event_holds_bit: assert property (
        event_q[1][5] && !ev_clr[1] |=> event_q[1][5])
        else $error("Operation event bit dropped without a read.");

    a_interlock_ignore: assert property (!ilk_en_q |-> !interlock_trip_o)
        else $error("Interlock acted while disabled.");

    a_pin_polarity: assert property (
        wr_done && wb_req_i.adr == ADR_CTRL && wb_req_i.sel[1]
        |=> pin_one_on_o == !$past(wb_req_i.dat[CTRL_PIN1]))
        else $error("Pin one switch state does not follow the written bit inverted.");

    a_pin_two_polarity: assert property (
        wr_done && wb_req_i.adr == ADR_CTRL && wb_req_i.sel[1]
        |=> pin_two_on_o == !$past(wb_req_i.dat[CTRL_PIN2]))
        else $error("Pin two switch state does not follow the written bit inverted.");

    a_scpi_sticky: assert property (protocol_scpi_o |=> protocol_scpi_o)
        else $error("Protocol fell back without a reset.");

    a_src_refused: assert property (
        wr_done && wb_req_i.adr == ADR_CTRL && wb_req_i.dat[CTRL_VSRC+1 -: 2] == 2'h3
        |=> $stable(volt_src_o))
        else $error("Invalid voltage source code was accepted.");

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge stood for more than one cycle.");

    a_word_reply_wraps: assert property (
        rd_done && wb_req_i.adr == ADR_SUM_CHAR && sum_last
        |=> sum_f_q == 3'd0 && sum_p_q == 3'd0)
        else $error("Status word_reply did not restart after its last character.");

endmodule : sas_aux_status

// ---- dv/sas_plant_model.sv ----
// Model of the supply's power stage: live measurements and status condition levels.
// Assumes the bench commands the condition levels; they appear one clock later.
`timescale 1ns/1ps
module sas_plant_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] fault_dem_i,
    input  wire logic [15:0] oper_dem_i,
    output logic      [15:0] fault_cond_o,
    output logic      [15:0] oper_cond_o,
    output logic      [15:0] meas_volt_o,
    output logic      [15:0] set_volt_o,
    output logic      [15:0] meas_curr_o,
    output logic      [15:0] set_curr_o
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_cond_o <= 16'h0000;
            oper_cond_o  <= 16'h0000;
        end
        else
        begin
            fault_cond_o <= fault_dem_i;
            oper_cond_o  <= oper_dem_i;
        end
    end
    // Letter digits in every field exercise the upper-case hex rendering.
    assign meas_volt_o = 16'h9A0F;
    assign set_volt_o  = 16'hB1C2;
    assign meas_curr_o = 16'h03DE;
    assign set_curr_o  = 16'hE5F4;
endmodule : sas_plant_model

// ---- dv/sas_aux_status_tb_top.sv ----
// Self-checking bench for the auxiliary settings and status registers.
// Assumes the design answers each Wishbone request with a one-cycle ack.
`timescale 1ns/1ps
module sas_aux_status_tb_top;
    import sas_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    sas_wb_req_t req = '0;
    logic        ilk_in = 1'b0;
    logic [15:0] fdem = 16'h0000;
    logic [15:0] odem = 16'h0000;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [15:0] fc, oc, mv, sv, mc, sc, bitc;
    logic        trip, wrd, scpi, rng, p1, p2;
    logic [1:0]  vs, cs;
    int          mismatches = 0;
    int          compares = 0;
    logic [31:0] src_txt [3] = '{32'h00444947, 32'h00564F4C, 32'h00524553};
    logic [15:0] nm [6] = '{16'h4D56, 16'h5056, 16'h4D43, 16'h5043, 16'h5352, 16'h4652};
    logic [15:0] fv [6];
    logic [7:0]  q [$];
    logic [7:0]  b;
    logic [31:0] rd;

    always #2.5 clk_i = ~clk_i;

    sas_plant_model sas_plant_model_i (.clk_i(clk_i), .rst_i(rst_i), .fault_dem_i(fdem),
        .oper_dem_i(odem), .fault_cond_o(fc), .oper_cond_o(oc), .meas_volt_o(mv),
        .set_volt_o(sv), .meas_curr_o(mc), .set_curr_o(sc));

    sas_aux_status sas_aux_status_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .meas_volt_i(mv), .set_volt_i(sv),
        .meas_curr_i(mc), .set_curr_i(sc), .fault_cond_i(fc), .oper_cond_i(oc),
        .interlock_input_i(ilk_in), .interlock_trip_o(trip), .word_reply_o(wrd),
        .protocol_scpi_o(scpi), .volt_src_o(vs), .curr_src_o(cs), .range_10v_o(rng),
        .pin_one_on_o(p1), .pin_two_on_o(p2), .link_bit_cycles_o(bitc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // Holds the request until ack is sampled high, then idles one cycle.
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            mismatches++;
            close_out();
        end
        rd = wb_dat_o;
        req <= '0;
        @(posedge clk_i);
    endtask : xfer

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    function automatic logic [31:0] cw(logic f, logic s, logic i, logic [1:0] v,
                                       logic [1:0] c, logic r, logic a, logic z);
        return {22'h0, z, a, r, c, v, i, s, f};
    endfunction : cw

    function automatic logic [7:0] hc(logic [3:0] d);
        return (d < 4'hA) ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
    endfunction : hc

    initial
    begin
        #100000;
        mismatches++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(ADR_CTRL, 32'h00000300);
        rdc(ADR_QENA, 32'h0);
        rdc(ADR_OENA, 32'h0);
        rdc(ADR_QEVENT, 32'h0);
        rdc(ADR_OEVENT, 32'h0);
        chk({30'h0, p1, p2}, 32'h0);
        chk({16'h0, bitc}, 32'h000006C8);
        rdc(8'h3C, 32'h0);
        rdc(ADR_FMT_HI, 32'h44494749);
        rdc(ADR_FMT_LO, 32'h00000054);
        ilk_in <= 1'b1;
        rdc(ADR_ILK_WORD_REPLY, 32'h00000030);
        chk({31'h0, trip}, 32'h0);
        xfer(1'b1, ADR_CTRL, cw(1, 0, 1, 0, 0, 0, 1, 1));
        chk({31'h0, wrd}, 32'h1);
        rdc(ADR_FMT_HI, 32'h54455854);
        rdc(ADR_FMT_LO, 32'h0);
        rdc(ADR_ILK_WORD_REPLY, 32'h00004F4E);
        chk({31'h0, trip}, 32'h1);
        ilk_in <= 1'b0;
        rdc(ADR_ILK_WORD_REPLY, 32'h004F4646);
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b1, ADR_CTRL, cw(0, 0, 0, 2'(k), 2'(2 - k), k == 1, 1, 1));
            chk({30'h0, vs}, 32'(k));
            chk({30'h0, cs}, 32'(2 - k));
            rdc(ADR_VSRC_WORD_REPLY, src_txt[k]);
            rdc(ADR_CSRC_WORD_REPLY, src_txt[2 - k]);
            rdc(ADR_RNG_WORD_REPLY, (k == 1) ? 32'h00003130 : 32'h00000035);
            chk({31'h0, rng}, 32'(k == 1));
        end
        xfer(1'b1, ADR_CTRL, cw(0, 0, 0, 3, 3, 0, 0, 1));
        rdc(ADR_CTRL, cw(0, 0, 0, 2, 0, 0, 0, 1));
        chk({30'h0, p1, p2}, 32'h2);
        xfer(1'b1, ADR_CTRL, cw(0, 1, 0, 0, 0, 0, 1, 0));
        chk({30'h0, p1, p2}, 32'h1);
        chk({31'h0, scpi}, 32'h1);
        xfer(1'b1, ADR_CTRL, cw(0, 0, 0, 0, 0, 0, 1, 0));
        rdc(ADR_CTRL, cw(0, 1, 0, 0, 0, 0, 1, 0));
        for (int g = 0; g < 2; g++)
        begin
            b = g ? ADR_OCOND : ADR_QCOND;
            xfer(1'b1, b + 8'h04, 32'h0000FFFF);
            rdc(b + 8'h04, 32'h0000FFFF);
            xfer(1'b1, b + 8'h04, 32'h000000FF);
            rdc(b + 8'h04, 32'h000000FF);
            xfer(1'b1, b, 32'h00001234);
            if (g) odem <= 16'h0F0F; else fdem <= 16'h0F0F;
            repeat (4) @(posedge clk_i);
            rdc(b, 32'h00000F0F);
            rdc(b + 8'h08, 32'h0000000F);
            rdc(b + 8'h08, 32'h0);
            if (g) odem <= 16'h0FFF; else fdem <= 16'h0FFF;
            xfer(1'b1, b + 8'h08, 32'h0000FFFF);
            rdc(b + 8'h08, 32'h000000F0);
            if (g) odem <= 16'h0000; else fdem <= 16'h0000;
            repeat (4) @(posedge clk_i);
            rdc(b + 8'h08, 32'h0);
        end
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, scpi}, 32'h0);
        rdc(ADR_CTRL, 32'h00000300);
        rdc(ADR_OENA, 32'h0);
        fdem <= 16'hC0A5;
        odem <= 16'h04FF;
        repeat (3) @(posedge clk_i);
        fv = '{mv, sv, mc, sc, 16'h04FF, 16'hC0A5};
        for (int f = 0; f < 6; f++)
        begin
            q.push_back(nm[f][15:8]);
            q.push_back(nm[f][7:0]);
            for (int d = 3; d >= 0; d--)
                q.push_back(hc(fv[f][d*4 +: 4]));
            if (f < 5)
                q.push_back(8'h2C);
        end
        xfer(1'b1, ADR_SUM_CHAR, 32'h0);
        for (int i = 0; i < 41; i++)
            rdc(ADR_SUM_CHAR, {23'h0, 1'(i == 40), q[i]});
        close_out();
    end
endmodule : sas_aux_status_tb_top
